// ### design/mco_top.sv
// MAC-only command interpreter with open execution and AXI4-Lite registers
// Overview of operation
// - Decode the sixteen-bit command codes listed
// - MAC-only set when link interface off
// - Fetch 32 parameter bytes; open with link interface on is rejected before any 44-byte fetch
// - During open, honour only reset requests
// - Options change by modify or reopen
// - Bit 0 wraps; modify cannot change it
// - Bits 1, 2 mask ring interrupts
// - Bit 3 forwards unsupported management frames
// - Bit 4 forwards changed attention frames
// - Bit 5 pads route to 18 when list data count is 32 or more
// - Bit 6 holds whole frame; forced by bit 13, bit 14 or link interface on
// - Bit 8 forwards changed beacon frames
// - Bit 11 zero enables early release at 16 Mbps
// - Bit 13 copies all management frames
// - Bit 13 clears attention, beacon pass
// - Bit 14 copies all user frames
// - Bit 15 first buffer, size stored
// - Ten-millisecond wrapping stamp counter
// - Open completion posts status, code
// - Unknown code sets illegal reject bit
//
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "mco_cfg.svh"
module mco_top
	import mco_pkg::*;
#(
	parameter int TICK_CYCLES = `MCO_TICK_CYCLES
) (
	input  wire logic        ref_clk,
	input  wire logic        reset,
	input  wire logic        link_layer_interface_on,
	input  wire logic        ring_16m,
	input  wire logic [15:0] list_data_count,
	// AXI4-Lite slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Parameter block fetch
	output mco_dma_req_type  dma_req,
	input  wire logic        dma_done,
	input  wire logic [15:0] dma_options,
	// Interrupt requests from host and towards host
	input  wire logic        host_irq_req,
	input  wire logic        host_reset_req,
	output logic             host_irq_taken,
	output logic             cmd_status_irq,
	// Frame path options and stamp
	output mco_opts_type     opts,
	output logic             pad_enable,
	output logic [7:0]       pad_length,
	output logic [15:0]      time_stamp
);
	// Software-visible words
	logic [15:0]     host_command_word_reg;
	logic [15:0]     host_command_param_high_reg;
	logic [15:0]     host_command_param_low_reg;
	logic [15:0]     status_block_command_word_reg;
	logic [15:0]     status_block_param_first_reg;
	logic [15:0]     status_block_param_second_reg;
	logic [15:0]     raw_opts_reg;      // Options as last opened or modified
	logic            open_reg;          // Adapter open
	logic            cmd_pending_reg;   // Command word awaiting execution
	mco_state_type   state_reg;
	logic [31:0]     open_param_block_pointer;
	logic [15:0]     opts_next;
	// Bus handshake state
	logic            aw_held_reg;
	logic            w_held_reg;
	logic [7:0]      aw_addr_reg;
	logic [31:0]     w_data_reg;
	logic [3:0]      w_strb_reg;
	// Stamp timer
	logic [31:0]     tick_cnt_reg;

	// Known command codes of the MAC-only set
	function automatic logic cmd_known(input logic [15:0] c);
		unique case (c)
			`MCO_CMD_OPEN, `MCO_CMD_XMIT, `MCO_CMD_XMIT_HALT,
			`MCO_CMD_RECEIVE, `MCO_CMD_CLOSE, `MCO_CMD_GROUP,
			`MCO_CMD_FUNCT, `MCO_CMD_ERRLOG, `MCO_CMD_READ,
			`MCO_CMD_MODIFY, `MCO_CMD_RESTORE, `MCO_CMD_GROUP16,
			`MCO_CMD_BRIDGE_SET, `MCO_CMD_BRIDGE_CFG: cmd_known = 1'b1;
			default: cmd_known = 1'b0;
		endcase
	endfunction : cmd_known

	// Override forced bits ahead of use, per the fetched or modify options word
	function automatic logic [15:0] force_opts(input logic [15:0] o,
		input logic link_on);
		logic [15:0] r;
		r = o & ~(`MCO_OPT_RSVD_MASK);
		if (o[`MCO_OPT_MGMT_ALL]) begin
			r[`MCO_OPT_ATTN]   = 1'b0;
			r[`MCO_OPT_BEACON] = 1'b0;
		end
		if (link_on || o[`MCO_OPT_MGMT_ALL] || o[`MCO_OPT_USER_ALL])
			r[`MCO_OPT_HOLD] = 1'b1;
		if (link_on)
			r[`MCO_OPT_FIRST_BUF] = 1'b0;
		force_opts = r;
	endfunction : force_opts

	// Write decode: both halves present
	wire        wr_fire   = aw_held_reg && w_held_reg && !s_axi_bvalid;
	wire        wr_cmd    = wr_fire && aw_addr_reg == `MCO_ADDR_CMD;
	wire        wr_phi    = wr_fire && aw_addr_reg == `MCO_ADDR_PHI;
	wire        wr_plo    = wr_fire && aw_addr_reg == `MCO_ADDR_PLO;
	wire        wr_ok     = wr_cmd || wr_phi || wr_plo;
	// Busy during open keeps the command word from being overwritten
	wire        opening   = state_reg != MCO_IDLE;
	wire [15:0] cmd       = host_command_word_reg;
	wire        is_modify = cmd == `MCO_CMD_MODIFY;
	wire        start     = cmd_pending_reg && state_reg == MCO_IDLE;
	assign open_param_block_pointer =
		{host_command_param_high_reg, host_command_param_low_reg};

	// Modify keeps the wrap bit as opened
	assign opts_next = force_opts({host_command_param_low_reg[15:1],
		raw_opts_reg[`MCO_OPT_WRAP]}, link_layer_interface_on);

	// Read mux
	logic [15:0] rd_word;
	always_comb begin
		unique case (s_axi_araddr)
			`MCO_ADDR_CMD:  rd_word = host_command_word_reg;
			`MCO_ADDR_PHI:  rd_word = host_command_param_high_reg;
			`MCO_ADDR_PLO:  rd_word = host_command_param_low_reg;
			`MCO_ADDR_SCMD: rd_word = status_block_command_word_reg;
			`MCO_ADDR_SP0:  rd_word = status_block_param_first_reg;
			`MCO_ADDR_SP1:  rd_word = status_block_param_second_reg;
			`MCO_ADDR_OPT:  rd_word = raw_opts_reg;
			`MCO_ADDR_STAT: rd_word = {13'h0000, cmd_pending_reg,
				opening, open_reg};
			default:        rd_word = 16'h0000;
		endcase
	end
	wire rd_hit = s_axi_araddr <= `MCO_ADDR_STAT;

	// Write channel capture; each half held until the write fires, then both released together
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			aw_held_reg   <= 1'b0;
			w_held_reg    <= 1'b0;
			aw_addr_reg   <= 8'h00;
			w_data_reg    <= 32'h00000000;
			w_strb_reg    <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'h0;
		end else begin
			s_axi_awready <= !aw_held_reg && !s_axi_awready;
			s_axi_wready  <= !w_held_reg && !s_axi_wready;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (wr_fire) begin
				// Unmapped or read-only target answers SLVERR
				aw_held_reg  <= 1'b0;
				w_held_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? 2'h0 : 2'h2;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read channel: one-cycle answer
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= 2'h0;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= {16'h0000, rd_word};
				s_axi_rresp  <= rd_hit ? 2'h0 : 2'h2;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Host command block; low byte lanes only
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			host_command_word_reg       <= 16'h0000;
			host_command_param_high_reg <= 16'h0000;
			host_command_param_low_reg  <= 16'h0000;
			cmd_pending_reg             <= 1'b0;
		end else begin
			if (wr_cmd && w_strb_reg[1:0] == 2'h3 && !opening) begin
				host_command_word_reg <= w_data_reg[15:0];
				cmd_pending_reg       <= 1'b1;
			end else if (start) begin
				cmd_pending_reg <= 1'b0;
			end
			if (wr_phi && w_strb_reg[1:0] == 2'h3)
				host_command_param_high_reg <= w_data_reg[15:0];
			if (wr_plo && w_strb_reg[1:0] == 2'h3)
				host_command_param_low_reg <= w_data_reg[15:0];
		end
	end

	// Command sequencer: open fetch, option apply, status posting
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state_reg                     <= MCO_IDLE;
			open_reg                      <= 1'b0;
			raw_opts_reg                  <= 16'h0000;
			status_block_command_word_reg <= 16'h0000;
			status_block_param_first_reg  <= 16'h0000;
			status_block_param_second_reg <= 16'h0000;
			cmd_status_irq                <= 1'b0;
			dma_req                       <= '0;
		end else begin
			cmd_status_irq <= 1'b0;
			unique case (state_reg)
				MCO_IDLE: begin
					if (start) begin
						// MAC-only decode while link interface off
						if (!cmd_known(cmd) || link_layer_interface_on) begin
							status_block_command_word_reg <= `MCO_CMD_REJECT;
							status_block_param_first_reg  <= `MCO_REJ_ILLEGAL;
							status_block_param_second_reg <= cmd;
							cmd_status_irq                <= 1'b1;
						end else if (cmd == `MCO_CMD_OPEN && open_reg) begin
							status_block_command_word_reg <= `MCO_CMD_REJECT;
							status_block_param_first_reg  <= `MCO_REJ_OPEN;
							status_block_param_second_reg <= cmd;
							cmd_status_irq                <= 1'b1;
						end else if (cmd == `MCO_CMD_OPEN) begin
							dma_req.valid <= 1'b1;
							dma_req.addr  <= open_param_block_pointer;
							dma_req.bytes <= link_layer_interface_on ?
								`MCO_PB_BYTES_LINK : `MCO_PB_BYTES_MAC;
							state_reg     <= MCO_DMA_REQ;
						end else if ((is_modify || cmd == `MCO_CMD_CLOSE)
								&& !open_reg) begin
							status_block_command_word_reg <= `MCO_CMD_REJECT;
							status_block_param_first_reg  <= `MCO_REJ_CLOSED;
							status_block_param_second_reg <= cmd;
							cmd_status_irq                <= 1'b1;
						end else begin
							// Close ends wrap; modify updates live options
							if (cmd == `MCO_CMD_CLOSE)
								open_reg <= 1'b0;
							if (is_modify)
								raw_opts_reg <= opts_next;
							status_block_command_word_reg <= cmd;
							status_block_param_first_reg  <= 16'h0000;
							cmd_status_irq                <= 1'b1;
						end
					end
				end
				MCO_DMA_REQ: begin
					dma_req.valid <= 1'b0;
					state_reg     <= MCO_DMA_WAIT;
				end
				MCO_DMA_WAIT: begin
					if (dma_done) begin
						raw_opts_reg <= force_opts(dma_options,
							link_layer_interface_on);
						status_block_param_first_reg <=
							(dma_options & `MCO_OPT_RSVD_MASK) != 16'h0000 ?
							`MCO_OPEN_BAD_OPT : `MCO_OPEN_OK;
						state_reg <= MCO_APPLY;
					end
				end
				MCO_APPLY: begin
					open_reg  <= status_block_param_first_reg == `MCO_OPEN_OK;
					state_reg <= MCO_POST;
				end
				MCO_POST: begin
					status_block_command_word_reg <= `MCO_CMD_OPEN;
					cmd_status_irq                <= 1'b1;
					state_reg                     <= MCO_IDLE;
				end
				default: state_reg <= MCO_IDLE;
			endcase
		end
	end

	// Host interrupt acceptance: reset only while opening
	always_ff @(posedge ref_clk) begin
		if (reset)
			host_irq_taken <= 1'b0;
		else
			host_irq_taken <= host_reset_req || (host_irq_req && !opening);
	end

	// Options to the frame path; only wrap is gated by open
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			opts       <= '0;
			pad_enable <= 1'b0;
			pad_length <= 8'h00;
		end else begin
			opts.wrap                     <= open_reg && raw_opts_reg[`MCO_OPT_WRAP];
			opts.hard_fault_irq_mask      <= raw_opts_reg[`MCO_OPT_HARD_MASK];
			opts.soft_irq_mask            <= raw_opts_reg[`MCO_OPT_SOFT_MASK];
			opts.forward_unsupported_mgmt <= raw_opts_reg[`MCO_OPT_UNSUP];
			opts.forward_attention_mgmt   <= raw_opts_reg[`MCO_OPT_ATTN];
			opts.pad_route                <= raw_opts_reg[`MCO_OPT_PAD];
			opts.frame_hold               <= raw_opts_reg[`MCO_OPT_HOLD];
			opts.join_monitor_election    <= raw_opts_reg[`MCO_OPT_ELECT];
			opts.forward_beacon_mgmt      <= raw_opts_reg[`MCO_OPT_BEACON];
			// Early release only at 16 Mbps
			opts.early_release <= ring_16m && !raw_opts_reg[`MCO_OPT_NO_ETR];
			opts.promiscuous_mgmt_copy    <= raw_opts_reg[`MCO_OPT_MGMT_ALL];
			opts.promiscuous_user_copy    <= raw_opts_reg[`MCO_OPT_USER_ALL];
			opts.first_buffer_only        <= raw_opts_reg[`MCO_OPT_FIRST_BUF];
			// Short lists are passed unpadded
			pad_enable <= raw_opts_reg[`MCO_OPT_PAD]
				&& list_data_count >= `MCO_PAD_MIN_COUNT;
			pad_length <= `MCO_PAD_LEN;
		end
	end

	// Free-running stamp, wraps naturally at 16 bits
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			tick_cnt_reg <= 32'h00000000;
			time_stamp   <= 16'h0000;
		end else if (tick_cnt_reg == 32'(TICK_CYCLES - 1)) begin
			tick_cnt_reg <= 32'h00000000;
			time_stamp   <= time_stamp + 16'h0001;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
		end
	end

	// Checks
	sequence s_open_fetch;
		dma_req.valid ##1 !dma_req.valid;
	endsequence
	a_fetch_length: assert property (@(posedge ref_clk) disable iff (reset)
		$rose(dma_req.valid) |-> dma_req.bytes == (link_layer_interface_on ?
		`MCO_PB_BYTES_LINK : `MCO_PB_BYTES_MAC))
		else $error("parameter block length wrong");
	a_fetch_pulse: assert property (@(posedge ref_clk) disable iff (reset)
		$rose(dma_req.valid) |-> s_open_fetch)
		else $error("fetch request not one cycle");
	a_open_ignore: assert property (@(posedge ref_clk) disable iff (reset)
		(opening && host_irq_req && !host_reset_req) |=> !host_irq_taken)
		else $error("interrupt taken during open");
	a_reset_taken: assert property (@(posedge ref_clk) disable iff (reset)
		host_reset_req |=> host_irq_taken)
		else $error("reset request not taken");
	a_modify_wrap: assert property (@(posedge ref_clk) disable iff (reset)
		(state_reg == MCO_IDLE && !$past(state_reg == MCO_DMA_WAIT))
		|-> $stable(raw_opts_reg[`MCO_OPT_WRAP]))
		else $error("wrap changed outside open");
	a_hold_forced: assert property (@(posedge ref_clk) disable iff (reset)
		(raw_opts_reg[`MCO_OPT_MGMT_ALL] || raw_opts_reg[`MCO_OPT_USER_ALL])
		|-> raw_opts_reg[`MCO_OPT_HOLD])
		else $error("frame hold not forced");
	a_pass_cleared: assert property (@(posedge ref_clk) disable iff (reset)
		raw_opts_reg[`MCO_OPT_MGMT_ALL] |-> !raw_opts_reg[`MCO_OPT_ATTN]
		&& !raw_opts_reg[`MCO_OPT_BEACON])
		else $error("pass bits not cleared");
	a_open_post: assert property (@(posedge ref_clk) disable iff (reset)
		state_reg == MCO_APPLY |-> ##2 cmd_status_irq
		&& status_block_command_word_reg == `MCO_CMD_OPEN)
		else $error("open completion not posted");
	a_illegal_cmd: assert property (@(posedge ref_clk) disable iff (reset)
		(start && !cmd_known(cmd)) |=> cmd_status_irq
		&& status_block_param_first_reg == `MCO_REJ_ILLEGAL)
		else $error("unknown code not rejected");
	a_early_rel: assert property (@(posedge ref_clk) disable iff (reset)
		!ring_16m |=> !opts.early_release)
		else $error("early release at 4 Mbps");
endmodule : mco_top
`default_nettype wire

// ### dv/mco_host_model.sv
// Host memory model that answers parameter block fetches
`timescale 1ns/1ns
`default_nettype none
module mco_host_model
	import mco_pkg::*;
(
	input  wire logic            ref_clk,
	input  wire logic            reset,
	input  wire mco_dma_req_type dma_req,
	input  wire logic [15:0]     opt_word,
	input  wire logic [3:0]      delay,
	output logic                 dma_done,
	output logic [15:0]          dma_options,
	output logic [31:0]          seen_addr,
	output logic [5:0]           seen_bytes
);
	logic [4:0] wait_reg; // Cycles left before memory answers

	// One fetch at a time; a slow memory is set by delay
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			wait_reg    <= 5'h00;
			dma_done    <= 1'b0;
			dma_options <= 16'h0000;
			seen_addr   <= 32'h0000_0000;
			seen_bytes  <= 6'h00;
		end else begin
			dma_done    <= 1'b0;
			// Stale word is scrambled so it cannot pass for data
			dma_options <= ~dma_options;
			if (wait_reg != 5'h00) wait_reg <= wait_reg - 5'h01;
			if (dma_req.valid) begin
				wait_reg   <= {1'b0, delay} + 5'h01;
				seen_addr  <= dma_req.addr;
				seen_bytes <= dma_req.bytes;
			end else if (wait_reg == 5'h01) begin
				dma_done    <= 1'b1;
				dma_options <= opt_word;
			end
		end
	end
endmodule : mco_host_model
`default_nettype wire

// ### dv/mco_top_tb.sv
// Self-checking bench for the command and open unit
`timescale 1ns/1ns
`default_nettype none
`include "mco_cfg.svh"
`define CHK(n, e, g) begin \
	checks_done++; \
	if ((g) !== (e)) begin \
		err_total++; \
		$display("ERROR %s expected %0h seen %0h", n, e, g); \
	end \
end
module mco_top_tb
	import mco_pkg::*;
;
	logic            ref_clk, reset, link_on, ring_16m;
	logic [15:0]     list_cnt, opt_word, st_cmd, st_p0, st_p1, t0;
	logic [7:0]      awaddr, araddr, pad_len;
	logic            awvalid, wvalid, bready, arvalid, rready;
	logic            awready, wready, bvalid, arready, rvalid;
	logic [31:0]     wdata, rdata, rd, seen_addr;
	logic [3:0]      wstrb;
	logic [1:0]      bresp, rresp, resp;
	mco_dma_req_type dma_req;
	logic            dma_done, irq_req, rst_req, irq_taken, cs_irq, pad_en;
	logic [15:0]     dma_options, stamp;
	logic [5:0]      seen_bytes;
	mco_opts_type    opts;
	int              err_total, checks_done, irq_cnt, cyc;
	logic [15:0]     codes [10] = '{16'h0006, 16'h0004, 16'h0005,
		16'h0008, 16'h0009, 16'h000A, 16'h000B, 16'h000F, 16'h0010,
		16'h0011}; // Receive first, as a host should after open

	mco_top #(.TICK_CYCLES(10)) mco_top_inst (
		.ref_clk(ref_clk), .reset(reset), .link_layer_interface_on(link_on),
		.ring_16m(ring_16m), .list_data_count(list_cnt),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .dma_req(dma_req),
		.dma_done(dma_done), .dma_options(dma_options),
		.host_irq_req(irq_req), .host_reset_req(rst_req),
		.host_irq_taken(irq_taken), .cmd_status_irq(cs_irq), .opts(opts),
		.pad_enable(pad_en), .pad_length(pad_len), .time_stamp(stamp));

	mco_host_model mco_host_model_inst (
		.ref_clk(ref_clk), .reset(reset), .dma_req(dma_req),
		.opt_word(opt_word), .delay(4'hC), .dma_done(dma_done),
		.dma_options(dma_options), .seen_addr(seen_addr),
		.seen_bytes(seen_bytes));

	// 100 MHz clock
	always #5 ref_clk = ~ref_clk;

	// Pulses counted on the falling edge, clear of the sampling edge
	always @(negedge ref_clk) begin
		if (cs_irq === 1'b1) irq_cnt++;
	end

	// Watchdog against a hung handshake
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			print_verdict();
		end
	end

	task print_verdict();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : print_verdict

	// Write one word; both halves offered together, each dropped when taken
	// Ready stays high between calls, so no step assigns it twice;
	// only the watchdog ends a wait for the answer
	task axw(input logic [7:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		resp = bresp;
	endtask : axw

	// Read one word
	task axr(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		resp = rresp;
		rd = rdata;
	endtask : axr

	// Issue a command, optionally poke an interrupt during the fetch
	task run(input logic [15:0] code, input logic [31:0] p, input logic pr);
		int n;
		int c0;
		n = 0;
		c0 = irq_cnt;
		axw(`MCO_ADDR_PHI, {16'h0000, p[31:16]});
		axw(`MCO_ADDR_PLO, {16'h0000, p[15:0]});
		axw(`MCO_ADDR_CMD, {16'h0000, code});
		if (pr) begin
			irq_req <= 1'b1;
			repeat (3) @(posedge ref_clk);
			`CHK("irq taken", 1'b0, irq_taken)
			irq_req <= 1'b0;
			// A reset request must still get through while opening
			rst_req <= 1'b1;
			repeat (2) @(posedge ref_clk);
			`CHK("reset taken", 1'b1, irq_taken)
			rst_req <= 1'b0;
		end
		while (irq_cnt == c0 && n < 60) begin
			@(posedge ref_clk);
			n++;
		end
		`CHK("status irq", c0 + 1, irq_cnt)
		axr(`MCO_ADDR_SCMD);
		st_cmd = rd[15:0];
		axr(`MCO_ADDR_SP0);
		st_p0 = rd[15:0];
		axr(`MCO_ADDR_SP1);
		st_p1 = rd[15:0];
	endtask : run

	// Status block compare; offending code only on rejects
	task st(input logic [15:0] c, input logic [15:0] p0, input logic [15:0] p1);
		`CHK("status cmd", c, st_cmd)
		`CHK("status p0", p0, st_p0)
		if (c == `MCO_CMD_REJECT) `CHK("status p1", p1, st_p1)
	endtask : st

	// Options expected after overrides are folded in
	function mco_opts_type eo(input logic [15:0] w, input logic fast);
		eo = '{w[0], w[1], w[2], w[3], w[4] & ~w[13], w[5],
			w[6] | w[13] | w[14], w[7], w[8] & ~w[13], fast & ~w[11],
			w[13], w[14], w[15]};
	endfunction : eo

	initial begin
		{ref_clk, link_on, awvalid, wvalid, bready, arvalid, rready} = '0;
		{irq_req, rst_req, awaddr, araddr, wdata, irq_cnt, cyc} = '0;
		{err_total, checks_done} = '0;
		reset = 1'b1;
		ring_16m = 1'b1;
		list_cnt = 16'd40;
		wstrb = 4'hF;
		opt_word = 16'h2169;
		repeat (2) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		`CHK("opts at reset", 13'h0000, opts)
		axr(8'h24);
		`CHK("unmapped read", 2'b10, resp)
		axw(`MCO_ADDR_SCMD, 32'h0000_0001);
		`CHK("status write", 2'b10, resp)
		$display("test bus done");
		// Ordinary host requests are taken while nothing is opening
		irq_req <= 1'b1;
		repeat (2) @(posedge ref_clk);
		`CHK("irq idle", 1'b1, irq_taken)
		irq_req <= 1'b0;
		run(16'h0001, 32'h0, 1'b0);
		st(`MCO_CMD_REJECT, `MCO_REJ_ILLEGAL, 16'h0001);
		run(`MCO_CMD_CLOSE, 32'h0, 1'b0);
		st(`MCO_CMD_REJECT, `MCO_REJ_CLOSED, `MCO_CMD_CLOSE);
		$display("test reject done");
		run(`MCO_CMD_OPEN, 32'h1234_5678, 1'b1);
		st(`MCO_CMD_OPEN, `MCO_OPEN_OK, 16'h0);
		`CHK("dma addr", 32'h1234_5678, seen_addr)
		`CHK("dma bytes", 6'd32, seen_bytes)
		`CHK("opts", eo(16'h2169, 1'b1), opts)
		`CHK("pad on", 1'b1, pad_en)
		`CHK("pad len", 8'd18, pad_len)
		list_cnt <= 16'd31;
		repeat (2) @(posedge ref_clk);
		`CHK("pad short", 1'b0, pad_en)
		run(`MCO_CMD_OPEN, 32'h0, 1'b0);
		st(`MCO_CMD_REJECT, `MCO_REJ_OPEN, `MCO_CMD_OPEN);
		$display("test open done");
		for (int i = 0; i < 10; i++) begin
			run(codes[i], 32'h0, 1'b0);
			st(codes[i], 16'h0000, 16'h0);
		end
		`CHK("opts kept", eo(16'h2169, 1'b1), opts)
		run(`MCO_CMD_MODIFY, 32'h0000_80B0, 1'b0);
		st(`MCO_CMD_MODIFY, 16'h0000, 16'h0);
		`CHK("modify", eo(16'h80B1, 1'b1), opts)
		run(`MCO_CMD_CLOSE, 32'h0, 1'b0);
		st(`MCO_CMD_CLOSE, 16'h0000, 16'h0);
		$display("test modify done");
		ring_16m <= 1'b0;
		opt_word <= 16'h490E;
		run(`MCO_CMD_OPEN, 32'h0BAD_0010, 1'b1);
		st(`MCO_CMD_OPEN, `MCO_OPEN_OK, 16'h0);
		`CHK("reopen", eo(16'h490E, 1'b0), opts)
		run(`MCO_CMD_CLOSE, 32'h0, 1'b0);
		opt_word <= 16'h0600;
		run(`MCO_CMD_OPEN, 32'h0000_0040, 1'b1);
		st(`MCO_CMD_OPEN, `MCO_OPEN_BAD_OPT, 16'h0);
		link_on <= 1'b1;
		run(`MCO_CMD_OPEN, 32'h0, 1'b0);
		st(`MCO_CMD_REJECT, `MCO_REJ_ILLEGAL, `MCO_CMD_OPEN);
		link_on <= 1'b0;
		$display("test reopen done");
		t0 = stamp;
		repeat (30) @(posedge ref_clk);
		`CHK("stamp", 16'h0003, 16'(stamp - t0))
		$display("test stamp done");
		print_verdict();
	end
endmodule : mco_top_tb
`default_nettype wire

// ### inc/mco_cfg.svh
// Constants for the MAC-only command and open unit
`ifndef MCO_CFG_SVH
`define MCO_CFG_SVH
// Command codes
`define MCO_CMD_REJECT      16'h0002
`define MCO_CMD_OPEN        16'h0003
`define MCO_CMD_XMIT        16'h0004
`define MCO_CMD_XMIT_HALT   16'h0005
`define MCO_CMD_RECEIVE     16'h0006
`define MCO_CMD_CLOSE       16'h0007
`define MCO_CMD_GROUP       16'h0008
`define MCO_CMD_FUNCT       16'h0009
`define MCO_CMD_ERRLOG      16'h000A
`define MCO_CMD_READ        16'h000B
`define MCO_CMD_MODIFY      16'h000D
`define MCO_CMD_RESTORE     16'h000E
`define MCO_CMD_GROUP16     16'h000F
`define MCO_CMD_BRIDGE_SET  16'h0010
`define MCO_CMD_BRIDGE_CFG  16'h0011
// Parameter block lengths in bytes
`define MCO_PB_BYTES_MAC    6'd32
`define MCO_PB_BYTES_LINK   6'd44
// Option bit positions
`define MCO_OPT_WRAP        0
`define MCO_OPT_HARD_MASK   1
`define MCO_OPT_SOFT_MASK   2
`define MCO_OPT_UNSUP       3
`define MCO_OPT_ATTN        4
`define MCO_OPT_PAD         5
`define MCO_OPT_HOLD        6
`define MCO_OPT_ELECT       7
`define MCO_OPT_BEACON      8
`define MCO_OPT_NO_ETR      11
`define MCO_OPT_MGMT_ALL    13
`define MCO_OPT_USER_ALL    14
`define MCO_OPT_FIRST_BUF   15
// Reserved option bits 9, 10, 12
`define MCO_OPT_RSVD_MASK   16'h1600
// Completion and reject values
`define MCO_OPEN_OK         16'h0001
`define MCO_OPEN_BAD_OPT    16'h0080
`define MCO_REJ_ILLEGAL     16'h0001
`define MCO_REJ_OPEN        16'h0004
`define MCO_REJ_CLOSED      16'h0008
// Routing pad figures
`define MCO_PAD_LEN         8'd18
`define MCO_PAD_MIN_COUNT   16'd32
// Timestamp tick
`define MCO_TICK_MS         10
`define MCO_CLK_MHZ         100
`define MCO_TICK_CYCLES     (`MCO_TICK_MS * 1000 * `MCO_CLK_MHZ)
// Register byte addresses
`define MCO_ADDR_CMD        8'h00
`define MCO_ADDR_PHI        8'h04
`define MCO_ADDR_PLO        8'h08
`define MCO_ADDR_SCMD       8'h0C
`define MCO_ADDR_SP0        8'h10
`define MCO_ADDR_SP1        8'h14
`define MCO_ADDR_OPT        8'h18
`define MCO_ADDR_STAT       8'h1C
`define MCO_ADDR_CTRL       8'h20
`endif

// ### inc/mco_pkg.sv
// Types for the MAC-only command and open unit
package mco_pkg;
	// Command interpreter states
	typedef enum logic [2:0] {
		MCO_IDLE, MCO_DMA_REQ, MCO_DMA_WAIT, MCO_APPLY, MCO_POST
	} mco_state_type;
	// Effective options driven to the frame path
	typedef struct packed {
		logic wrap;
		logic hard_fault_irq_mask;
		logic soft_irq_mask;
		logic forward_unsupported_mgmt;
		logic forward_attention_mgmt;
		logic pad_route;
		logic frame_hold;
		logic join_monitor_election;
		logic forward_beacon_mgmt;
		logic early_release;
		logic promiscuous_mgmt_copy;
		logic promiscuous_user_copy;
		logic first_buffer_only;
	} mco_opts_type;
	// Host memory read request
	typedef struct packed {
		logic        valid;
		logic [31:0] addr;
		logic [5:0]  bytes;
	} mco_dma_req_type;
endpackage : mco_pkg
